//--- rtl/sbc_pkg.sv
// shared constants and carriers for the command block status engine
package sbc_pkg;

  // word offsets inside a command block, in bytes from the base
  localparam logic [17:0] STAT_OFS  = 18'h00002; // status word
  localparam logic [17:0] CMD_OFS   = 18'h00004; // command word

  // status word field positions
  localparam int          DONE_BIT  = 15;        // buffer used flag
  localparam int          RSV_HI    = 14;        // unused field, top
  localparam int          RSV_LO    = 8;         // unused field, bottom

  // command word field positions
  localparam int          IRQ_BIT   = 15;        // completion request
  localparam int          TID_HI    = 2;         // target select, top
  localparam int          TID_LO    = 0;         // target select, bottom

  // interrupt priority level and vector offset
  localparam logic [4:0]  IRQ_LEVEL = 5'h0E;
  localparam logic [8:0]  IRQ_VEC   = 9'h0C4;

  // reset values
  localparam logic [17:0] BASE_RST  = 18'h00000;
  localparam logic [15:0] WORD_RST  = 16'h0000;
  localparam logic [7:0]  BYTE_RST  = 8'h00;
  localparam logic [2:0]  TID_RST   = 3'h0;

  // bus events, packed in status word bit order 7 down to 0
  typedef struct packed {
    logic bus_reset;    // bit 7
    logic timeout;      // bit 6
    logic xsum_bad;     // bit 5, target only
    logic bad_phase;    // bit 4, initiator only
    logic no_ack;       // bit 3, initiator only
    logic early_phase;  // bit 2, initiator only
    logic cmd_err;      // bit 1, target only
    logic parity;       // bit 0
  } sbc_evt_t;

  // buffer ram request carrier
  typedef struct packed {
    logic        req;   // request, held until ack
    logic        we;    // write when set
    logic [17:0] addr;  // byte address
    logic [15:0] wdata; // write data
  } sbc_mem_t;

  // engine states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_RSTAT = 6'b000010,
    ST_RCMD  = 6'b000100,
    ST_ACT   = 6'b001000,
    ST_SEND  = 6'b010000,
    ST_WSTAT = 6'b100000
  } sbc_state_t;

endpackage

//--- rtl/sbc_sticky.sv
`timescale 1ns/100ps
// bank of sticky flags; a set in the clear cycle wins
module sbc_sticky #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst,
  // set and clear
  input  wire logic [W-1:0] i_set,
  input  wire logic         i_clr,
  // held flags
  output logic      [W-1:0] o_q
);

  logic [W-1:0] q_q; // flag storage
  logic [W-1:0] q_d; // next flags

  // clear first, then or in new sets
  always_comb begin
    q_d = (i_clr ? '0 : q_q) | i_set;
  end

  // flag register
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      q_q <= '0;
    end else begin
      q_q <= q_d;
    end
  end

  assign o_q = q_q;

endmodule // sbc_sticky

//--- rtl/sbc_engine.sv
`timescale 1ns/100ps
module sbc_engine (
  // clock and reset
  input  wire logic            i_clk_sys,
  input  wire logic            i_rst,
  // buffer hand-in from the list walker
  input  wire logic            i_start,     // pulse, take buffer
  input  wire logic [17:0]     i_base,      // command block base
  input  wire logic            i_tgt_role,  // set: target role
  // link progress from the bus sequencer
  input  wire sbc_pkg::sbc_evt_t i_evt,     // event pulses
  input  wire logic            i_status_in, // status-in reached
  input  wire logic            i_txn_end,   // transaction over
  input  wire logic            i_tgt_gone,  // target left early
  input  wire logic            i_no_dev,    // select found nobody
  // buffer ram
  output sbc_pkg::sbc_mem_t    o_mem,
  input  wire logic            i_mem_ack,
  input  wire logic [15:0]     i_mem_rdata,
  // to the bus sequencer
  output logic                 o_go,        // pulse, buffer accepted
  output logic                 o_skip,      // pulse, buffer skipped
  output logic [2:0]           o_target_id, // target to select
  output logic                 o_stat_vld,  // pulse, status byte
  output logic [7:0]           o_stat_byte,
  output logic                 o_oe_clr,    // pulse, drop output enable
  output logic                 o_busy,
  // interrupt request
  output logic                 o_irq,       // pulse
  output logic [4:0]           o_irq_level,
  output logic [8:0]           o_irq_vec
);

  // all engine state
  typedef struct packed {
    sbc_pkg::sbc_state_t st;   // engine state
    logic [17:0]         base; // current block base
    logic                tgt;  // role of this buffer
    logic                ie;   // completion interrupt wanted
    logic                stin; // status-in phase reached
    sbc_pkg::sbc_mem_t   mem;  // ram request
    logic                go;
    logic                skip;
    logic [2:0]          tid;
    logic                svld;
    logic [7:0]          sbyte;
    logic                oeclr;
    logic                busy;
    logic                irq;
    logic [4:0]          lvl;
    logic [8:0]          vec;
  } sbc_eng_t;

  sbc_eng_t          s_q;      // registered state
  sbc_eng_t          s_d;      // next state
  sbc_pkg::sbc_evt_t evt_ok;   // events valid for role
  logic [7:0]        flags;    // sticky flags of the buffer
  logic              flg_clr;  // wipe flags for a new buffer
  logic              reached;  // status-in seen, this cycle too
  logic              early_ab; // abort before status-in

  // keep only events that mean something in this role
  always_comb begin
    evt_ok             = i_evt;
    evt_ok.xsum_bad    = i_evt.xsum_bad & s_q.tgt;
    evt_ok.cmd_err     = i_evt.cmd_err & s_q.tgt;
    evt_ok.bad_phase   = i_evt.bad_phase & ~s_q.tgt;
    evt_ok.no_ack      = i_evt.no_ack & ~s_q.tgt;
    evt_ok.early_phase = i_evt.early_phase & ~s_q.tgt;
  end

  assign flg_clr  = (s_q.st == sbc_pkg::ST_IDLE) & i_start;
  assign reached  = s_q.stin | i_status_in;
  assign early_ab = ~reached & (i_evt.bus_reset | i_evt.timeout);

  // flags gather only while the transaction runs
  sbc_sticky #(
    .W (8)
  ) u_flags (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_set     ((s_q.st == sbc_pkg::ST_ACT) ? evt_ok : 8'h00),
    .i_clr     (flg_clr),
    .o_q       (flags)
  );

  // next state and outputs
  always_comb begin
    s_d       = s_q;
    s_d.go    = 1'b0;
    s_d.skip  = 1'b0;
    s_d.svld  = 1'b0;
    s_d.oeclr = 1'b0;
    s_d.irq   = 1'b0;
    s_d.lvl   = sbc_pkg::IRQ_LEVEL;
    s_d.vec   = sbc_pkg::IRQ_VEC;
    case (s_q.st)
      // wait for a buffer, then read its status word
      sbc_pkg::ST_IDLE: begin
        if (i_start) begin
          s_d.base      = i_base;
          s_d.tgt       = i_tgt_role;
          s_d.stin      = 1'b0;
          s_d.busy      = 1'b1;
          s_d.mem.req   = 1'b1;
          s_d.mem.we    = 1'b0;
          s_d.mem.addr  = i_base + sbc_pkg::STAT_OFS;
          s_d.st        = sbc_pkg::ST_RSTAT;
        end
      end
      // used flag already set: leave the buffer alone
      sbc_pkg::ST_RSTAT: begin
        if (i_mem_ack) begin
          if (i_mem_rdata[sbc_pkg::DONE_BIT]) begin
            s_d.mem.req = 1'b0;
            s_d.skip    = 1'b1;
            s_d.busy    = 1'b0;
            s_d.st      = sbc_pkg::ST_IDLE;
          end else begin
            s_d.mem.addr = s_q.base + sbc_pkg::CMD_OFS;
            s_d.st       = sbc_pkg::ST_RCMD;
          end
        end
      end
      // take interrupt request, and target id when initiating
      sbc_pkg::ST_RCMD: begin
        if (i_mem_ack) begin
          s_d.mem.req = 1'b0;
          s_d.ie      = i_mem_rdata[sbc_pkg::IRQ_BIT];
          s_d.tid     = s_q.tgt ? sbc_pkg::TID_RST :
                        i_mem_rdata[sbc_pkg::TID_HI:sbc_pkg::TID_LO];
          s_d.go      = 1'b1;
          s_d.st      = sbc_pkg::ST_ACT;
        end
      end
      // transaction on the bus
      sbc_pkg::ST_ACT: begin
        if (i_status_in) begin
          s_d.stin = 1'b1;
        end
        if (early_ab) begin
          // bus reset or timeout before status-in: no write
          s_d.oeclr = 1'b1;
          s_d.irq   = 1'b1;
          s_d.busy  = 1'b0;
          s_d.st    = sbc_pkg::ST_IDLE;
        end else if (~reached & (i_tgt_gone | i_no_dev)) begin
          // nobody to finish with: no write
          s_d.irq  = s_q.ie;
          s_d.busy = 1'b0;
          s_d.st   = sbc_pkg::ST_IDLE;
        end else if (i_txn_end & reached) begin
          s_d.st = s_q.tgt ? sbc_pkg::ST_SEND : sbc_pkg::ST_WSTAT;
        end
      end
      // target hands its status byte to the initiator
      sbc_pkg::ST_SEND: begin
        s_d.svld  = 1'b1;
        s_d.sbyte = flags;
        s_d.st    = sbc_pkg::ST_WSTAT;
      end
      // write the status word once, then finish
      sbc_pkg::ST_WSTAT: begin
        if (~s_q.mem.req) begin
          s_d.mem.req   = 1'b1;
          s_d.mem.we    = 1'b1;
          s_d.mem.addr  = s_q.base + sbc_pkg::STAT_OFS;
          s_d.mem.wdata = {1'b1, 7'h00, flags};
        end else if (i_mem_ack) begin
          s_d.mem.req = 1'b0;
          s_d.mem.we  = 1'b0;
          s_d.irq     = s_q.ie;
          s_d.busy    = 1'b0;
          s_d.st      = sbc_pkg::ST_IDLE;
        end
      end
      default: begin
        s_d.st      = sbc_pkg::ST_IDLE;
        s_d.mem.req = 1'b0;
        s_d.busy    = 1'b0;
      end
    endcase
  end

  // state register
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      s_q       <= '0;
      s_q.st    <= sbc_pkg::ST_IDLE;
      s_q.base  <= sbc_pkg::BASE_RST;
      s_q.sbyte <= sbc_pkg::BYTE_RST;
      s_q.tid   <= sbc_pkg::TID_RST;
      s_q.mem   <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign o_mem       = s_q.mem;
  assign o_go        = s_q.go;
  assign o_skip      = s_q.skip;
  assign o_target_id = s_q.tid;
  assign o_stat_vld  = s_q.svld;
  assign o_stat_byte = s_q.sbyte;
  assign o_oe_clr    = s_q.oeclr;
  assign o_busy      = s_q.busy;
  assign o_irq       = s_q.irq;
  assign o_irq_level = s_q.lvl;
  assign o_irq_vec   = s_q.vec;

  // used flag read as set leads to a skip next cycle
  a_used_skip: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_q.st == sbc_pkg::ST_RSTAT && i_mem_ack &&
    i_mem_rdata[sbc_pkg::DONE_BIT] |=> o_skip && !o_go && !o_mem.req)
    else $error("used buffer not skipped");

  // every status write carries the used flag and zero spare bits
  a_write_format: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_mem.req && o_mem.we |-> o_mem.wdata[sbc_pkg::DONE_BIT] &&
    o_mem.wdata[sbc_pkg::RSV_HI:sbc_pkg::RSV_LO] == 7'h00)
    else $error("status word format wrong");

  // status goes to base plus two
  a_write_addr: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_mem.req && o_mem.we |-> o_mem.addr == s_q.base + sbc_pkg::STAT_OFS)
    else $error("status written to wrong address");

  // early bus reset drops output, interrupts, never writes
  a_reset_abort: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_q.st == sbc_pkg::ST_ACT && !reached && i_evt.bus_reset
    |=> o_oe_clr && o_irq && !o_mem.we ##1 !o_mem.we)
    else $error("early bus reset mishandled");

  // early timeout drops output, interrupts, returns to idle
  a_tmo_abort: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_q.st == sbc_pkg::ST_ACT && !reached && i_evt.timeout
    |=> o_oe_clr && o_irq && s_q.st == sbc_pkg::ST_IDLE)
    else $error("early timeout mishandled");

  // target only bits stay clear when initiating
  a_tgt_bits: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_mem.req && o_mem.we && !s_q.tgt |-> !o_mem.wdata[5] && !o_mem.wdata[1])
    else $error("target bit set as initiator");

  // initiator only bits stay clear as target
  a_ini_bits: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_mem.req && o_mem.we && s_q.tgt |-> o_mem.wdata[4:2] == 3'h0)
    else $error("initiator bit set as target");

  // status byte goes out just before the write request
  a_send_write: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_stat_vld |-> s_q.tgt ##1 o_mem.req && o_mem.we &&
    o_mem.wdata[7:0] == $past(o_stat_byte))
    else $error("status byte not followed by write");

  // completion interrupt only when asked for, at fixed level
  a_irq_ie: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_irq && !o_oe_clr |-> s_q.ie && o_irq_level == sbc_pkg::IRQ_LEVEL)
    else $error("interrupt without request");

  // parity seen as the transaction ends shows in bit 0 of the write
  a_parity_bit: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_q.st == sbc_pkg::ST_ACT && reached && i_txn_end && i_evt.parity
    |-> ##[1:4] o_mem.req && o_mem.we && o_mem.wdata[0])
    else $error("parity flag lost");

  // leaving target or missing device writes nothing
  a_gone_nowrite: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_q.st == sbc_pkg::ST_ACT && !reached && !early_ab &&
    (i_tgt_gone || i_no_dev) |=> s_q.st == sbc_pkg::ST_IDLE && !o_mem.req)
    else $error("status written after lost peer");

endmodule // sbc_engine

//--- bench/sbc_ram_model.sv
`timescale 1ns/100ps
// buffer ram behind the engine, answers after a set wait
module sbc_ram_model (
  // clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst,
  // request side
  input  wire sbc_pkg::sbc_mem_t i_mem,
  input  wire logic [3:0]        i_wait,
  // answer side
  output logic                   o_ack,
  output logic [15:0]            o_rdata
);
  logic [15:0] mem [0:127]; // word store, byte address bits 7:1
  logic [3:0]  cnt_q;       // cycles waited on this request

  // one request at a time; data toggles when not answering
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_ack   <= 1'b0;
      o_rdata <= 16'h5A5A;
      cnt_q   <= 4'h0;
    end else if (o_ack) begin
      // request completes on this edge
      o_ack   <= 1'b0;
      o_rdata <= ~o_rdata;
      if (i_mem.we) begin
        mem[i_mem.addr[7:1]] <= i_mem.wdata;
      end
    end else if (i_mem.req && cnt_q == i_wait) begin
      o_ack   <= 1'b1;
      o_rdata <= mem[i_mem.addr[7:1]];
      cnt_q   <= 4'h0;
    end else begin
      // stall, data toggles each cycle, never held steady
      o_rdata <= ~o_rdata;
      cnt_q   <= i_mem.req ? cnt_q + 4'h1 : 4'h0;
    end
  end
endmodule // sbc_ram_model

//--- bench/sbc_engine_test.sv
`timescale 1ns/100ps
// self-checking bench for the command block status engine
module sbc_engine_test;
  // stimulus
  logic              clk_sys, rst, start, tgt_role;
  logic [17:0]       base;
  sbc_pkg::sbc_evt_t evt;
  logic              status_in, txn_end, tgt_gone, no_dev;
  logic [3:0]        ram_wait;
  // engine outputs
  sbc_pkg::sbc_mem_t mem_bus;
  logic              mem_ack, go, skip, stat_vld, oe_clr, busy, irq;
  logic [15:0]       mem_rdata;
  logic [2:0]        target_id;
  logic [7:0]        stat_byte, stat_seen;
  logic [4:0]        irq_level;
  logic [8:0]        irq_vec;
  // pulse tallies and verdict counters
  int                irq_n, oe_n, stat_n, go_n, skip_n;
  int                mismatches, samples_checked;

  sbc_engine dut_u (.i_clk_sys(clk_sys), .i_rst(rst), .i_start(start),
    .i_base(base), .i_tgt_role(tgt_role), .i_evt(evt),
    .i_status_in(status_in), .i_txn_end(txn_end), .i_tgt_gone(tgt_gone),
    .i_no_dev(no_dev), .o_mem(mem_bus), .i_mem_ack(mem_ack),
    .i_mem_rdata(mem_rdata), .o_go(go), .o_skip(skip),
    .o_target_id(target_id), .o_stat_vld(stat_vld),
    .o_stat_byte(stat_byte), .o_oe_clr(oe_clr), .o_busy(busy),
    .o_irq(irq), .o_irq_level(irq_level), .o_irq_vec(irq_vec));

  sbc_ram_model ram_u (.i_clk_sys(clk_sys), .i_rst(rst), .i_mem(mem_bus),
    .i_wait(ram_wait), .o_ack(mem_ack), .o_rdata(mem_rdata));

  // 250 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // compare and tally
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // one-cycle pulses counted where they stand
  always @(negedge clk_sys) begin
    if (irq === 1'b1) begin
      irq_n++;
      chk({7'h0, irq_vec}, 16'h00C4);
      chk({11'h0, irq_level}, 16'h000E);
    end
    if (oe_clr === 1'b1) oe_n++;
    if (go === 1'b1) go_n++;
    if (skip === 1'b1) skip_n++;
    if (stat_vld === 1'b1) begin
      stat_n++;
      stat_seen = stat_byte;
    end
  end

  // load a command block, hand it in, wait for accept or skip
  task automatic hand_in(input logic [17:0] b, input logic t,
                         input logic [15:0] st, input logic [15:0] cmd);
    int k;
    ram_u.mem[b[7:1] + 7'h1] = st;
    ram_u.mem[b[7:1] + 7'h2] = cmd;
    {irq_n, oe_n, stat_n, go_n, skip_n} = '0;
    base = b;
    tgt_role = t;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    for (k = 0; k < 40 && go_n == 0 && skip_n == 0; k++) tick(1);
  endtask

  // one cycle of bus sequencer progress
  task automatic pulse_evt(input logic [7:0] e, input logic si,
                           input logic te, input logic g, input logic nd);
    evt = e;
    {status_in, txn_end, tgt_gone, no_dev} = {si, te, g, nd};
    tick(1);
    evt = 8'h00;
    {status_in, txn_end, tgt_gone, no_dev} = 4'h0;
    // idle edge, so a following call never rewrites a level in one step
    tick(1);
  endtask

  task automatic settle();
    int k;
    for (k = 0; k < 40 && busy !== 1'b0; k++) tick(1);
    tick(2);
  endtask

  // initiator, every flag raised, interrupt asked for
  task automatic sc_init_all();
    hand_in(18'h00040, 1'b0, 16'h0000, 16'h8005);
    chk({13'h0, target_id}, 16'h0005);
    chk(16'(go_n), 16'h0001);
    chk({15'h0, busy}, 16'h0001);
    pulse_evt(8'h00, 1'b1, 1'b0, 1'b0, 1'b0);
    pulse_evt(8'hFF, 1'b1, 1'b1, 1'b0, 1'b0);
    settle();
    chk(ram_u.mem[7'h21], 16'h80DD);
    chk(16'(irq_n), 16'h0001);
    chk(16'(stat_n), 16'h0000);
  endtask

  // target role on a slow ram, no interrupt asked for
  task automatic sc_tgt_all();
    ram_wait = 4'h3;
    hand_in(18'h00048, 1'b1, 16'h0000, 16'h0003);
    chk({13'h0, target_id}, 16'h0000);
    pulse_evt(8'hFF, 1'b1, 1'b1, 1'b0, 1'b0);
    settle();
    chk(16'(stat_n), 16'h0001);
    chk({8'h0, stat_seen}, 16'h00E3);
    chk(ram_u.mem[7'h25], 16'h80E3);
    chk(16'(irq_n), 16'h0000);
    ram_wait = 4'h0;
  endtask

  // used flag already set: buffer left alone
  task automatic sc_skip();
    hand_in(18'h00050, 1'b0, 16'h8123, 16'h8001);
    settle();
    chk(16'(skip_n), 16'h0001);
    chk(16'(go_n), 16'h0000);
    chk({15'h0, busy}, 16'h0000);
    chk(ram_u.mem[7'h29], 16'h8123);
    chk(16'(irq_n), 16'h0000);
  endtask

  // bus reset, then timeout, before status-in
  task automatic sc_early_abort();
    int k;
    for (k = 0; k < 2; k++) begin
      hand_in(18'h00058, 1'b0, 16'h0000, 16'h0002);
      pulse_evt(k == 0 ? 8'h80 : 8'h40, 1'b0, 1'b0, 1'b0, 1'b0);
      settle();
      chk(16'(oe_n), 16'h0001);
      chk(16'(irq_n), 16'h0001);
      chk(ram_u.mem[7'h2D], 16'h0000);
    end
  endtask

  // absent device or departed target: no status, irq only if asked
  task automatic sc_no_status();
    int k;
    for (k = 0; k < 4; k++) begin
      hand_in(18'h00060, 1'b0, 16'h0000, {k[1], 15'h0001});
      pulse_evt(8'h01, 1'b0, 1'b0, ~k[0], k[0]);
      settle();
      chk(ram_u.mem[7'h31], 16'h0000);
      chk(16'(irq_n), {15'h0, k[1]});
    end
  endtask

  task automatic close_out();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    {start, tgt_role, status_in, txn_end, tgt_gone, no_dev} = '0;
    base = 18'h00000;
    evt = 8'h00;
    ram_wait = 4'h0;
    mismatches = 0;
    samples_checked = 0;
    rst = 1'b1;
    tick(16);
    rst = 1'b0;
    tick(1);
    sc_init_all();
    sc_tgt_all();
    sc_skip();
    sc_early_abort();
    sc_no_status();
    close_out();
  end

  // cut a hang short after 5000 cycles
  initial begin
    #20000;
    mismatches++;
    close_out();
  end
endmodule // sbc_engine_test
